// *** rtl/twecp_top.sv ***
// serial command port of a small eeprom: framing, decode, read, status
// ==================================================
`timescale 1ns/1ps
`include "twecp_defines.svh"
module twecp_top
	import twecp_pkg::*;
#(
	parameter bit ORG_X16 = 1'b0,
	parameter int PROG_CYCLES = `TWECP_T_WC_MS * `TWECP_NS_PER_MS
		/ `TWECP_CLK_PERIOD_NS,
	parameter int ALL_CYCLES = `TWECP_T_WL_MS * `TWECP_NS_PER_MS
		/ `TWECP_CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs,
	input wire logic sclk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe
);
	// ==================================================
	// frame geometry per organisation
	localparam int AW = ORG_X16 ? `TWECP_AW_X16 : `TWECP_AW_X8;
	localparam int DW = ORG_X16 ? `TWECP_DW_X16 : `TWECP_DW_X8;
	localparam int HB = `TWECP_OPC_BITS + AW;
	localparam int CW = `TWECP_CNT_W;

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic ck_m;
		logic ck_s;
		logic di_m;
		logic di_s;
		logic ck_p;
		logic cs_p;
		twecp_state_e state;
		logic [CW-1:0] cnt;
		logic [HB-1:0] hdr;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic [DW-1:0] rword;
		logic load;
		logic unlock;
		twecp_op_e pend;
		logic start;
		logic arm;
		logic stat;
		logic so;
		logic oe;
	} twecp_ctrl_s;

	twecp_ctrl_s q, d;
	logic ck_rise;
	logic cs_fall;
	logic cs_rise;
	logic busy_any;
	logic [HB-1:0] hdr_n;
	logic [1:0] opc_n;
	logic [1:0] sub_n;

	twecp_core_if #(.AW(AW), .DW(DW)) core_bus ();

	twecp_array #(
		.AW(AW),
		.DW(DW),
		.PROG_CYCLES(PROG_CYCLES),
		.ALL_CYCLES(ALL_CYCLES)
	) u_array (
		.clk(clk),
		.rst_n(rst_n),
		.port(core_bus.core)
	);

	// ==================================================
	// edges of the synchronised pins, header with the incoming bit
	assign ck_rise = q.ck_s & ~q.ck_p;
	assign cs_fall = q.cs_p & ~q.cs_s;
	assign cs_rise = q.cs_s & ~q.cs_p;
	// the start pulse covers the cycle before the engine shows busy
	assign busy_any = core_bus.busy | q.start;
	assign hdr_n = {q.hdr[HB-2:0], q.di_s};
	assign opc_n = hdr_n[HB-1 -: 2];
	assign sub_n = hdr_n[AW-1 -: 2];

	// ==================================================
	// command sequencer
	always_comb begin
		d = q;
		// pins pass two flops before anything looks at them
		d.cs_m = cs;
		d.cs_s = q.cs_m;
		d.ck_m = sclk;
		d.ck_s = q.ck_m;
		d.di_m = serial_in;
		d.di_s = q.di_m;
		d.ck_p = q.ck_s;
		d.cs_p = q.cs_s;
		d.start = 1'b0;
		d.load = 1'b0;
		// fetch of a read word, one clock after the address is known
		if (q.load) begin
			d.rword = core_bus.rd_data;
		end
		// deselect: release the output and launch any armed cycle
		if (cs_fall) begin
			d.oe = 1'b0;
			d.stat = 1'b0;
			if (q.pend != OP_NONE) begin
				d.start = 1'b1;
				d.arm = 1'b1;
			end
		end
		// the engine takes the operation with the start pulse: hold it till then
		if (q.start) begin
			d.pend = OP_NONE;
		end
		// reselect after a launched cycle: show ready or busy
		if (cs_rise && q.arm) begin
			d.stat = 1'b1;
			d.oe = 1'b1;
			// level valid from the first driven cycle, no stale read bit
			d.so = ~busy_any;
		end
		if (q.stat) begin
			d.so = ~busy_any;
		end
		if (!q.cs_s) begin
			d.state = ST_WAIT;
			d.cnt = '0;
		end else if (ck_rise) begin
			unique case (q.state)
				ST_WAIT: begin
					// no new frame while a cycle runs: status stays up
					if (q.di_s && !busy_any) begin
						d.state = ST_HEAD;
						d.cnt = '0;
						d.oe = 1'b0;
						d.stat = 1'b0;
						d.arm = 1'b0;
					end
				end
				ST_HEAD: begin
					d.hdr = hdr_n;
					d.cnt = q.cnt + CW'(1);
					if (q.cnt == CW'(HB - 1)) begin
						d.addr = hdr_n[AW-1:0];
						d.cnt = '0;
						d.state = ST_DONE;
						unique case (opc_n)
							`TWECP_OPC_READ: begin
								// dummy zero goes out with the last address bit
								d.state = ST_READ;
								d.load = 1'b1;
								d.so = 1'b0;
								d.oe = 1'b1;
							end
							`TWECP_OPC_WRITE: begin
								d.state = ST_DATA;
							end
							`TWECP_OPC_ERASE: begin
								if (q.unlock) begin
									d.pend = OP_ERASE;
								end
							end
							`TWECP_OPC_SPECIAL: begin
								unique case (sub_n)
									`TWECP_SUB_ERASE_ENTIRE_ARRAY: begin
										if (q.unlock) begin
											d.pend = OP_ERASE_ENTIRE_ARRAY;
										end
									end
									`TWECP_SUB_LOCK: begin
										d.unlock = 1'b0;
									end
									`TWECP_SUB_UNLOCK: begin
										d.unlock = 1'b1;
									end
									`TWECP_SUB_WRITE_ENTIRE_ARRAY: begin
										d.state = ST_DATA;
									end
								endcase
							end
						endcase
					end
				end
				ST_DATA: begin
					d.wdata = {q.wdata[DW-2:0], q.di_s};
					d.cnt = q.cnt + CW'(1);
					if (q.cnt == CW'(DW - 1)) begin
						d.state = ST_DONE;
						if (q.unlock) begin
							d.pend = (q.hdr[HB-1 -: 2] == `TWECP_OPC_WRITE)
								? OP_WRITE : OP_WRITE_ENTIRE_ARRAY;
						end
					end
				end
				ST_READ: begin
					d.so = q.rword[DW-1];
					d.rword = {q.rword[DW-2:0], 1'b0};
					d.cnt = q.cnt + CW'(1);
					if (q.cnt == CW'(DW - 1)) begin
						// sequential read: next word has no dummy bit
						d.cnt = '0;
						d.addr = q.addr + AW'(1);
						d.load = 1'b1;
					end
				end
				ST_DONE: begin
					// frame complete: edges ignored until select drops
					d.state = ST_DONE;
				end
			endcase
		end
	end

	// ==================================================
	// state register; reset acts as power-up, so programming is locked
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==================================================
	// outputs and engine link, all from flops
	assign serial_out = q.so;
	assign serial_out_oe = q.oe;
	assign core_bus.start = q.start;
	assign core_bus.op = q.pend;
	assign core_bus.addr = q.addr;
	assign core_bus.data = q.wdata;
	assign core_bus.rd_addr = q.addr;

	// ==================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_cs_fall;
		q.cs_p && !q.cs_s;
	endsequence

	sequence s_start_edge;
		q.cs_s && q.state == ST_WAIT && ck_rise && q.di_s && !busy_any;
	endsequence

	chk_cs_reset_seq: assert property (
		!q.cs_s |=> q.state == ST_WAIT
	) else $error("sequencer not held in reset while deselected");

	chk_cs_release_out: assert property (
		s_cs_fall |=> !q.oe
	) else $error("output not released on select fall");

	chk_hiz_default: assert property (
		q.oe |-> q.stat || q.state == ST_READ
	) else $error("output driven outside read or status");

	chk_wait_idle: assert property (
		q.state == ST_WAIT && !(ck_rise && q.di_s) |=> q.state == ST_WAIT
	) else $error("left waiting without a start condition");

	chk_start_seen: assert property (
		s_start_edge |=> q.state == ST_HEAD && !q.oe && q.cnt == '0
	) else $error("start condition not taken");

	chk_pause_hold: assert property (
		q.cs_s && !ck_rise |=> $stable(q.cnt) && $stable(q.hdr)
			&& $stable(q.wdata)
	) else $error("received bits changed without a clock edge");

	chk_frame_done: assert property (
		q.cs_s && q.state == ST_DONE |=> q.state == ST_DONE
	) else $error("completed frame reacted to further clocks");

	chk_dummy_zero: assert property (
		$rose(q.state == ST_READ) |-> q.oe && !q.so ##1 q.oe && !q.so
	) else $error("read did not open with a dummy zero");

	chk_seq_addr: assert property (
		q.cs_s && ck_rise && q.state == ST_READ && q.cnt == CW'(DW - 1)
			|=> q.load && q.addr == $past(q.addr) + AW'(1)
	) else $error("sequential read did not advance the address");

	chk_prog_start: assert property (
		s_cs_fall ##0 (q.pend != OP_NONE) |=> q.start ##1 core_bus.busy
	) else $error("programming cycle not launched on select fall");

	chk_lock_guard: assert property (
		q.start |-> q.unlock
	) else $error("programming launched while locked");

	chk_status_level: assert property (
		q.stat && $past(q.stat) |-> q.oe && q.so == !$past(busy_any)
	) else $error("status level does not track ready");
endmodule

// *** rtl/twecp_defines.svh ***
// constants of the three-wire eeprom command port
`ifndef TWECP_DEFINES_SVH
`define TWECP_DEFINES_SVH

// ==================================================
// timing
`define TWECP_CLK_PERIOD_NS 10
`define TWECP_NS_PER_MS 1000000
`define TWECP_T_WC_MS 6
`define TWECP_T_WL_MS 15
`define TWECP_DESELECT_GAP_TIME_NS 250

// ==================================================
// opcode field
`define TWECP_OPC_SPECIAL 2'h0
`define TWECP_OPC_WRITE 2'h1
`define TWECP_OPC_READ 2'h2
`define TWECP_OPC_ERASE 2'h3

// ==================================================
// sub-command in the two top address bits under opcode special
`define TWECP_SUB_LOCK 2'h0
`define TWECP_SUB_WRITE_ENTIRE_ARRAY 2'h1
`define TWECP_SUB_ERASE_ENTIRE_ARRAY 2'h2
`define TWECP_SUB_UNLOCK 2'h3

// ==================================================
// frame shape
`define TWECP_OPC_BITS 2
`define TWECP_AW_X8 7
`define TWECP_AW_X16 6
`define TWECP_DW_X8 8
`define TWECP_DW_X16 16
`define TWECP_CNT_W 5

`endif

// *** rtl/twecp_pkg.sv ***
// shared types of the three-wire eeprom command port
package twecp_pkg;

	// ==================================================
	// command sequencer states
	typedef enum logic [2:0] {
		ST_WAIT,
		ST_HEAD,
		ST_DATA,
		ST_READ,
		ST_DONE
	} twecp_state_e;

	// ==================================================
	// self-timed programming operations
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ERASE,
		OP_WRITE,
		OP_ERASE_ENTIRE_ARRAY,
		OP_WRITE_ENTIRE_ARRAY
	} twecp_op_e;

endpackage

// *** rtl/twecp_core_if.sv ***
// link between the command sequencer and the array engine
`timescale 1ns/1ps
interface twecp_core_if #(
	parameter int AW = 7,
	parameter int DW = 8
);
	import twecp_pkg::*;

	logic start;
	twecp_op_e op;
	logic [AW-1:0] addr;
	logic [DW-1:0] data;
	logic busy;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;

	modport ctrl (
		output start,
		output op,
		output addr,
		output data,
		output rd_addr,
		input busy,
		input rd_data
	);

	modport core (
		input start,
		input op,
		input addr,
		input data,
		input rd_addr,
		output busy,
		output rd_data
	);
endinterface

// *** rtl/twecp_array.sv ***
// storage array and self-timed erase and program engine
`timescale 1ns/1ps
`include "twecp_defines.svh"
module twecp_array
	import twecp_pkg::*;
#(
	parameter int AW = 7,
	parameter int DW = 8,
	parameter int PROG_CYCLES = 600000,
	parameter int ALL_CYCLES = 1500000
) (
	input wire logic clk,
	input wire logic rst_n,
	twecp_core_if.core port
);
	localparam int DEPTH = 1 << AW;
	localparam int TW = $clog2(ALL_CYCLES + 1);

	typedef struct packed {
		logic busy;
		logic [TW-1:0] timer;
		twecp_op_e op;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic pass2;
		logic [AW-1:0] idx;
	} twecp_eng_s;

	twecp_eng_s q, d;
	logic [DW-1:0] mem [DEPTH];
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wval;

	// ==================================================
	// engine: wait out the cycle time, then commit the cells
	always_comb begin
		d = q;
		we = 1'b0;
		waddr = q.addr;
		wval = '1;
		if (!q.busy) begin
			// runs without any serial clock once started
			if (port.start) begin
				d.busy = 1'b1;
				d.op = port.op;
				d.addr = port.addr;
				d.data = port.data;
				d.timer = (port.op == OP_WRITE_ENTIRE_ARRAY) ? TW'(ALL_CYCLES - 1)
					: TW'(PROG_CYCLES - 1);
				d.pass2 = 1'b0;
				d.idx = '0;
			end
		end else if (q.timer != '0) begin
			d.timer = q.timer - TW'(1);
		end else begin
			unique case (q.op)
				OP_ERASE: begin
					we = 1'b1;
					d.busy = 1'b0;
				end
				OP_WRITE: begin
					// erase folded in: final cell value is the data
					we = 1'b1;
					wval = q.data;
					d.busy = 1'b0;
				end
				OP_ERASE_ENTIRE_ARRAY, OP_WRITE_ENTIRE_ARRAY: begin
					// one word per cycle; whole-array write adds a pass
					we = 1'b1;
					waddr = q.idx;
					wval = (q.op == OP_WRITE_ENTIRE_ARRAY && q.pass2) ? q.data : '1;
					d.idx = q.idx + AW'(1);
					if (q.idx == AW'(DEPTH - 1)) begin
						if (q.op == OP_WRITE_ENTIRE_ARRAY && !q.pass2) begin
							d.pass2 = 1'b1;
						end else begin
							d.busy = 1'b0;
						end
					end
				end
				default: begin
					d.busy = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// cells are not reset: contents survive a control reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wval;
		end
	end

	assign port.busy = q.busy;
	assign port.rd_data = mem[port.rd_addr];

	// ==================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_busy_on_start: assert property (
		!q.busy && port.start |=> q.busy
	) else $error("engine did not go busy on start");

	chk_erase_ones: assert property (
		we && (q.op == OP_ERASE || q.op == OP_ERASE_ENTIRE_ARRAY)
			|=> mem[$past(waddr)] == '1
	) else $error("erase left a cell with a zero bit");
endmodule

// *** test/twecp_host.sv ***
// host-side serial master model of the eeprom command port
`timescale 1ns/1ps
module twecp_host (
	input wire logic clk,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	output logic cs,
	output logic sclk,
	output logic serial_in
);
	// ==================================================
	// idle pins; sclk stands still outside frames
	initial begin
		cs = 1'b0;
		sclk = 1'b0;
		serial_in = 1'b0;
	end

	// one link clock; bit set up a whole half period before the rise
	task automatic bit_io(input logic b, output logic o);
		@(posedge clk) #1;
		serial_in = b;
		repeat (8) @(posedge clk);
		#1 sclk = 1'b1;
		repeat (8) @(posedge clk);
		// a released line reads as z, so a missing enable never matches
		#1 o = serial_out_oe ? serial_out : 1'bz;
		sclk = 1'b0;
	endtask

	// pre idle clocks with the line low, then n bits msb first
	task automatic frame(input int pre, input int n, input logic [31:0] bits,
		output logic [31:0] got);
		logic o;
		got = '0;
		cs = 1'b1;
		repeat (pre) bit_io(1'b0, o);
		for (int i = n - 1; i >= 0; i--) begin
			bit_io(bits[i], o);
			got = {got[30:0], o};
		end
	endtask

	// deselect for lo cycles with the data line toggling, then select
	task automatic gap(input int lo);
		@(posedge clk) #1;
		cs = 1'b0;
		repeat (lo) begin
			@(posedge clk) #1;
			serial_in = ~serial_in;
		end
		cs = 1'b1;
		repeat (8) @(posedge clk);
		#1;
	endtask
endmodule

// *** test/tb.sv ***
// self-checking bench of the eeprom command port, byte and word organisation
`timescale 1ns/1ps
`include "twecp_defines.svh"
module tb;
	// short cycles keep the run small and let polling finish within its 1000-cycle bound
	localparam int PROG = 200;
	localparam int ALL = 400;
	logic clk, rst_n, cs, sclk, serial_in, serial_out, serial_out_oe;
	integer seed = 32'h15af;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] got;
	logic [6:0] a;
	logic [7:0] d, d2;
	logic [5:0] a2;
	logic [15:0] w;
	logic [1:0] word_pin;

	twecp_top #(.ORG_X16(1'b0), .PROG_CYCLES(PROG), .ALL_CYCLES(ALL))
	twecp_top_inst (.clk(clk), .rst_n(rst_n), .cs(cs), .sclk(sclk),
		.serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe));
	twecp_host twecp_host_inst (.clk(clk), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .cs(cs), .sclk(sclk),
		.serial_in(serial_in));

	// ==================================================
	// word organisation on its own pair, same clock and reset
	if (1) begin : g_word
		logic cs, sclk, serial_in, serial_out, serial_out_oe;
		twecp_top #(.ORG_X16(1'b1), .PROG_CYCLES(PROG), .ALL_CYCLES(ALL))
		twecp_top_inst (.clk(clk), .rst_n(rst_n), .cs(cs), .sclk(sclk),
			.serial_in(serial_in), .serial_out(serial_out),
			.serial_out_oe(serial_out_oe));
		twecp_host twecp_host_inst (.clk(clk), .serial_out(serial_out),
			.serial_out_oe(serial_out_oe), .cs(cs), .sclk(sclk),
			.serial_in(serial_in));
	end
	assign word_pin = {g_word.serial_out_oe, g_word.serial_out};

	// ==================================================
	// checking and closing
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==================================================
	// frame building and transactions
	function automatic logic [31:0] frm(logic [1:0] opc, logic [6:0] ad,
		logic [7:0] dt);
		return {14'h0000, 1'b1, opc, ad, dt};
	endfunction

	// command of 10 clocks, or 18 with a data byte, then a normal gap
	task automatic cmd(input logic [1:0] opc, input logic [6:0] ad,
		input logic [7:0] dt, input bit with_data);
		logic [31:0] f;
		f = frm(opc, ad, dt);
		if (with_data)
			twecp_host_inst.frame({$random(seed)} % 4, 18, f, got);
		else
			twecp_host_inst.frame({$random(seed)} % 4, 10, f >> 8, got);
		twecp_host_inst.gap(30);
	endtask

	// read k words: dummy zero then words msb first, then line released
	task automatic rd(input logic [6:0] ad, input int k,
		input logic [15:0] exp);
		logic [31:0] m;
		m = (32'h0000_0001 << (8 * k + 1)) - 32'h0000_0001;
		twecp_host_inst.frame(0, 10 + 8 * k,
			frm(`TWECP_OPC_READ, ad, 8'h00) << (8 * (k - 1)), got);
		check("read word", got & m, {16'h0000, exp});
		twecp_host_inst.gap(30);
		check("oe after read", serial_out_oe, 1'b0);
	endtask

	// busy level first, then ready within a bounded wait
	task automatic poll();
		check("busy", {serial_out_oe, serial_out}, 2'b10);
		// look only after the edge has settled the output
		for (int i = 0; i < 1000 && serial_out !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		check("ready", {serial_out_oe, serial_out}, 2'b11);
	endtask

	// ==================================================
	// clock, reset and the cycle ceiling
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			summarize();
		end
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		a = 7'($random(seed));
		d = 8'($random(seed));
		check("oe reset", serial_out_oe, 1'b0);
		cmd(`TWECP_OPC_WRITE, a, d, 1);
		check("locked write", serial_out_oe, 1'b0);
		$display("test locked done");
		cmd(`TWECP_OPC_SPECIAL, {`TWECP_SUB_UNLOCK, 5'h15}, 8'h00, 0);
		check("unlock quiet", serial_out_oe, 1'b0);
		repeat (3) begin
			a = 7'($random(seed));
			d = 8'($random(seed));
			cmd(`TWECP_OPC_WRITE, a, d, 1);
			poll();
			rd(a, 1, {8'h00, d});
		end
		$display("test write read done");
		d2 = 8'($random(seed));
		twecp_host_inst.frame(1, 18, frm(`TWECP_OPC_WRITE, a + 7'h01, d2),
			got);
		twecp_host_inst.gap(PROG + 50);
		check("late status", {serial_out_oe, serial_out}, 2'b11);
		rd(a, 2, {d, d2});
		cmd(`TWECP_OPC_ERASE, a, 8'h00, 0);
		poll();
		rd(a, 1, 16'h00ff);
		$display("test erase done");
		cmd(`TWECP_OPC_SPECIAL, {`TWECP_SUB_ERASE_ENTIRE_ARRAY, 5'h03}, 8'h00, 0);
		poll();
		rd(a + 7'h01, 1, 16'h00ff);
		cmd(`TWECP_OPC_SPECIAL, {`TWECP_SUB_WRITE_ENTIRE_ARRAY, 5'h1c}, d, 1);
		poll();
		rd(a ^ 7'h55, 1, {8'h00, d});
		$display("test array ops done");
		cmd(`TWECP_OPC_SPECIAL, {`TWECP_SUB_LOCK, 5'h0e}, 8'h00, 0);
		cmd(`TWECP_OPC_ERASE, a, 8'h00, 0);
		check("locked erase", serial_out_oe, 1'b0);
		rd(a, 1, {8'h00, d});
		// a write cut short by deselect must launch nothing
		cmd(`TWECP_OPC_SPECIAL, {`TWECP_SUB_UNLOCK, 5'h00}, 8'h00, 0);
		twecp_host_inst.frame(0, 14, frm(`TWECP_OPC_WRITE, a, d2) >> 4,
			got);
		twecp_host_inst.gap(30);
		check("cut frame", serial_out_oe, 1'b0);
		rd(a, 1, {8'h00, d});
		$display("test lock and cut done");
		// word organisation: unlock, write, status, read back
		a2 = 6'($random(seed));
		w = 16'($random(seed));
		g_word.twecp_host_inst.frame(0, 9, {23'h00_0000, 1'b1,
			`TWECP_OPC_SPECIAL, `TWECP_SUB_UNLOCK, 4'h0}, got);
		g_word.twecp_host_inst.gap(30);
		g_word.twecp_host_inst.frame(1, 25, {7'h00, 1'b1,
			`TWECP_OPC_WRITE, a2, w}, got);
		g_word.twecp_host_inst.gap(30);
		check("word busy", word_pin, 2'b10);
		g_word.twecp_host_inst.gap(PROG + 50);
		check("word ready", word_pin, 2'b11);
		g_word.twecp_host_inst.frame(0, 25, {7'h00, 1'b1,
			`TWECP_OPC_READ, a2, 16'h0000}, got);
		check("word read", got & 32'h0001_ffff, {16'h0000, w});
		g_word.twecp_host_inst.gap(30);
		check("word oe off", word_pin[1], 1'b0);
		$display("test word organisation done");
		summarize();
	end
endmodule
